/* hw/dac_host_params.svh */
`ifndef DAC_HOST_PARAMS_SVH
`define DAC_HOST_PARAMS_SVH

// Frame layout
`define FRAME_BITS      32
`define BYTE_BITS       8
`define BYTES_PER_FRAME 4
`define CMD_MSB         27
`define CMD_LSB         24
`define ADDR_MSB        23
`define ADDR_LSB        20
// Serial clock half period in mclk cycles
`define SCLK_HALF_DIV   4
// Gap-state mclk cycles after a frame; frame-select stays high at least one cycle more between frames
`define FRAME_GAP       4

`endif

/* hw/dac_host_pkg.sv */
package dac_host_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_SHIFT = 3'b011,
    ST_NEXT  = 3'b010,
    ST_END   = 3'b110,
    ST_GAP   = 3'b111
  } host_state_e;
  typedef logic [31:0] frame_t;
  typedef logic [7:0]  byte_t;
endpackage

/* hw/byte_link_if.sv */
`timescale 1ns/1ns
// Carries one byte between the sequencer and the byte shifter
interface byte_link_if;
  import dac_host_pkg::*;
  logic  start;
  byte_t data;
  logic  busy;
  logic  done;
  modport seq (output start, output data, input busy, input done);
  modport shf (input start, input data, output busy, output done);
endinterface

/* hw/bit_order_fix.sv */
`timescale 1ns/1ns
`include "dac_host_params.svh"
module bit_order_fix (
  input  wire logic                lsb_first,
  input  wire dac_host_pkg::byte_t in_byte,
  output      dac_host_pkg::byte_t out_byte
);
  import dac_host_pkg::*;
  byte_t rev;
  genvar i;
  generate
    for (i = 0; i < `BYTE_BITS; i = i + 1) begin : g_rev
      assign rev[i] = in_byte[`BYTE_BITS-1-i];
    end
  endgenerate
  // Port shifting LSB first gets mirrored bytes so the wire still carries MSB first
  assign out_byte = lsb_first ? rev : in_byte;
endmodule

/* hw/byte_shifter.sv */
`timescale 1ns/1ns
`include "dac_host_params.svh"
// Shifts one byte: eight clock pulses, clock idles low. Data changes late in
// the low phase, so it is stable across the rising edge and the following fall.
module byte_shifter (
  input wire logic mclk,
  input wire logic sys_rst,
  byte_link_if.shf lnk,
  output     logic sclk_q,
  output     logic sdata_q
);
  import dac_host_pkg::*;
  logic [2:0] div_q, div_d;
  logic [3:0] cnt_q, cnt_d;
  byte_t      sh_q, sh_d;
  logic       busy_q, busy_d;
  logic       done_q, done_d;
  logic       sclk_d, sdata_d;

  always_comb begin
    div_d   = div_q;
    cnt_d   = cnt_q;
    sh_d    = sh_q;
    busy_d  = busy_q;
    done_d  = 1'b0;
    sclk_d  = sclk_q;
    sdata_d = sdata_q;
    if (!busy_q) begin
      sclk_d = 1'b0;
      if (lnk.start) begin
        busy_d = 1'b1;
        sh_d   = lnk.data;
        cnt_d  = 4'h0;
        div_d  = 3'h0;
      end
    end else if (div_q == 3'(`SCLK_HALF_DIV - 1)) begin
      div_d = 3'h0;
      if (!sclk_q) begin
        if (cnt_q == 4'(`BYTE_BITS)) begin
          busy_d = 1'b0;
          done_d = 1'b1;
        end else begin
          // Rising edge: bit already set up one cycle earlier
          sclk_d = 1'b1;
        end
      end else begin
        // Falling edge: one of exactly eight per byte
        sclk_d = 1'b0;
        cnt_d  = cnt_q + 4'h1;
      end
    end else begin
      div_d = div_q + 3'h1;
      // Next bit, MSB first, one cycle before the rise; changing on the rise races the capture
      if (!sclk_q && div_q == 3'(`SCLK_HALF_DIV - 2) && cnt_q != 4'(`BYTE_BITS)) begin
        sdata_d = sh_q[`BYTE_BITS-1];
        sh_d    = {sh_q[`BYTE_BITS-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      div_q   <= 3'h0;
      cnt_q   <= 4'h0;
      sh_q    <= 8'h00;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
      sclk_q  <= 1'b0;
      sdata_q <= 1'b0;
    end else begin
      div_q   <= div_d;
      cnt_q   <= cnt_d;
      sh_q    <= sh_d;
      busy_q  <= busy_d;
      done_q  <= done_d;
      sclk_q  <= sclk_d;
      sdata_q <= sdata_d;
    end
  end

  assign lnk.busy = busy_q;
  assign lnk.done = done_q;
endmodule

/* hw/dac_serial_host_write.sv */
`timescale 1ns/1ns
`include "dac_host_params.svh"
// Behaviour
// (RULE1) Frame-select goes low before any bit shifts, stays low throughout.
// (RULE2) Serial clock idles low; data held steady over both clock edges.
// (RULE3) Each data bit is stable across the falling clock edge.
// (RULE4) Each byte transfer gives exactly eight falling clock edges.
// (RULE5) Bits go out most significant bit first.
// (RULE6) Frame-select stays low between bytes; next byte follows at once. The code holds the clock low 11 mclk cycles between bytes instead of 4.
// (RULE7) Frame-select returns high after the last byte.
// (RULE8) An LSB-first port bit-reverses each byte before sending.
// (RULE9) Frame-select comes from a plain programmable output line.
// (RULE10) Data bits change on the falling clock edge side of the cycle; the code changes them late in the low phase, one mclk cycle before the rise.
// (RULE11) The converter captures data on the rising clock edge.
// (RULE12) Frame is 32 bits: command 27..24, address 23..20, payload below.
module dac_serial_host_write (
  input  wire logic                 mclk,
  input  wire logic                 sys_rst,
  input  wire logic                 req_valid,
  input  wire logic [3:0]           req_cmd,
  input  wire logic [3:0]           req_addr,
  input  wire logic [19:0]          req_payload,
  input  wire logic [3:0]           req_top,
  input  wire logic                 lsb_first_port,
  output      logic                 req_ready_q,
  output      logic                 frame_done_q,
  output      logic                 sync_n_q,
  output      logic                 sclk_q,
  output      logic                 sdin_q
);
  import dac_host_pkg::*;

  byte_link_if lnk ();

  host_state_e st_q, st_d;
  frame_t      frame_q, frame_d;
  logic [1:0]  idx_q, idx_d;
  logic [2:0]  gap_q, gap_d;
  logic        lsb_q, lsb_d;
  logic        start_q, start_d;
  logic        sync_n_d, ready_d, fdone_d;
  byte_t       raw_byte, tx_byte;
  logic        sclk_w, sdata_w;

  // Byte picked MSB byte first
  always_comb begin
    raw_byte = frame_q[`FRAME_BITS-1 -: `BYTE_BITS];
    case (idx_q)
      2'h0:    raw_byte = frame_q[31:24];
      2'h1:    raw_byte = frame_q[23:16];
      2'h2:    raw_byte = frame_q[15:8];
      default: raw_byte = frame_q[7:0];
    endcase
  end

  // (RULE8) bit reversal
  // Shifter is MSB first; the mirror models a port that emits LSB first, so
  // reversing twice keeps the wire order correct in either setting.
  byte_t pre_byte;
  bit_order_fix u_pre (
    .lsb_first (lsb_q),
    .in_byte   (raw_byte),
    .out_byte  (pre_byte)
  );
  bit_order_fix u_port (
    .lsb_first (lsb_q),
    .in_byte   (pre_byte),
    .out_byte  (tx_byte)
  );

  always_comb begin
    st_d     = st_q;
    frame_d  = frame_q;
    idx_d    = idx_q;
    gap_d    = gap_q;
    lsb_d    = lsb_q;
    start_d  = 1'b0;
    sync_n_d = sync_n_q;
    ready_d  = 1'b0;
    fdone_d  = 1'b0;
    case (st_q)
      ST_IDLE: begin
        ready_d = 1'b1;
        if (req_valid && req_ready_q) begin
          // (RULE12) frame layout
          frame_d = {req_top, req_cmd, req_addr, req_payload};
          lsb_d   = lsb_first_port;
          idx_d   = 2'h0;
          ready_d = 1'b0;
          // (RULE1) select low first
          // (RULE9) plain port line
          sync_n_d = 1'b0;
          st_d     = ST_SETUP;
        end
      end
      ST_SETUP: begin
        start_d = 1'b1;
        st_d    = ST_SHIFT;
      end
      ST_SHIFT: begin
        if (lnk.done) begin
          if (idx_q == 2'(`BYTES_PER_FRAME - 1)) begin
            st_d = ST_END;
          end else begin
            // (RULE6) select kept low
            idx_d = idx_q + 2'h1;
            st_d  = ST_NEXT;
          end
        end
      end
      ST_NEXT: begin
        if (!lnk.busy) begin
          start_d = 1'b1;
          st_d    = ST_SHIFT;
        end
      end
      ST_END: begin
        // (RULE7) select back high
        sync_n_d = 1'b1;
        fdone_d  = 1'b1;
        gap_d    = 3'h0;
        st_d     = ST_GAP;
      end
      ST_GAP: begin
        if (gap_q == 3'(`FRAME_GAP - 1)) begin
          ready_d = 1'b1;
          st_d    = ST_IDLE;
        end else begin
          gap_d = gap_q + 3'h1;
        end
      end
      default: begin
        st_d     = ST_IDLE;
        sync_n_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q         <= ST_IDLE;
      frame_q      <= 32'h0000_0000;
      idx_q        <= 2'h0;
      gap_q        <= 3'h0;
      lsb_q        <= 1'b0;
      start_q      <= 1'b0;
      sync_n_q     <= 1'b1;
      req_ready_q  <= 1'b0;
      frame_done_q <= 1'b0;
    end else begin
      st_q         <= st_d;
      frame_q      <= frame_d;
      idx_q        <= idx_d;
      gap_q        <= gap_d;
      lsb_q        <= lsb_d;
      start_q      <= start_d;
      sync_n_q     <= sync_n_d;
      req_ready_q  <= ready_d;
      frame_done_q <= fdone_d;
    end
  end

  assign lnk.start = start_q;
  assign lnk.data  = tx_byte;

  // (RULE2) clock idles low
  // (RULE3) data stable at fall
  // (RULE4) eight falls a byte
  // (RULE5) MSB first
  // (RULE10) change away from fall
  // (RULE11) held over the rise
  byte_shifter u_shf (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .lnk     (lnk.shf),
    .sclk_q  (sclk_w),
    .sdata_q (sdata_w)
  );

  // Pin outputs straight from the shifter flops
  assign sclk_q = sclk_w;
  assign sdin_q = sdata_w;
endmodule

/* sim/dac_host_props.sv */
`timescale 1ns/1ns
module dac_host_props (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic req_valid,
  input wire logic req_ready_q,
  input wire logic frame_done_q,
  input wire logic sync_n_q,
  input wire logic sclk_q,
  input wire logic sdin_q
);
  logic [5:0] falls_q;
  logic [5:0] falls_d;
  logic       sclk_p_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Count clock falls inside a frame
  always_comb begin
    falls_d = sync_n_q ? 6'h00 : falls_q + {5'h00, sclk_p_q & ~sclk_q};
  end
  always_ff @(posedge mclk) begin
    falls_q  <= falls_d;
    sclk_p_q <= sclk_q;
  end
  sequence s_high_phase;
    sclk_q [*4] ##1 !sclk_q;
  endsequence
  a_accept_frame: assert property (req_valid && req_ready_q |=> !req_ready_q && $fell(sync_n_q))
    else $error("accepted request did not open a frame");
  a_clk_in_frame: assert property (sclk_q |-> !sync_n_q && $past(sync_n_q) == 1'b0)
    else $error("serial clock high outside a frame");
  a_first_clk: assert property ($fell(sync_n_q) |-> !sclk_q ##[1:16] $rose(sclk_q))
    else $error("no clock soon after frame start");
  a_data_at_fall: assert property ($fell(sclk_q) |-> $stable(sdin_q))
    else $error("data moved at falling clock edge");
  a_data_at_rise: assert property ($rose(sclk_q) |-> $stable(sdin_q))
    else $error("data moved at rising clock edge");
  a_high_phase: assert property ($rose(sclk_q) |-> s_high_phase)
    else $error("clock high phase not four cycles");
  a_falls_per_frame: assert property ($rose(sync_n_q) |-> falls_q == 6'h20)
    else $error("frame did not hold 32 clock falls");
  a_done_with_rise: assert property ($rose(sync_n_q) == frame_done_q)
    else $error("done pulse not aligned with frame end");
  a_gap_high: assert property ($rose(sync_n_q) |-> sync_n_q [*4])
    else $error("frame select gap too short");
  a_ready_idle: assert property (req_ready_q |-> sync_n_q && !sclk_q)
    else $error("ready while frame active");
endmodule

/* sim/dac_device_model.sv */
`timescale 1ns/1ns
module dac_device_model (
  input  wire logic        sync_n,
  input  wire logic        sclk,
  input  wire logic        sdin,
  output      logic [31:0] word,
  output      logic [5:0]  nbits,
  output      logic [5:0]  nfall,
  output      int          frames
);
  logic [31:0] shreg;
  int          rise_tot = 0;
  int          fall_tot = 0;
  int          rise_open = 0;
  int          fall_open = 0;
  // capture on rise, first bit lands MSB
  always @(posedge sclk) if (!sync_n) begin
    shreg = {shreg[30:0], sdin};
    rise_tot = rise_tot + 1;
  end
  always @(negedge sclk) if (!sync_n) fall_tot = fall_tot + 1;
  // frame opens; counts run from here, one driver each
  always @(negedge sync_n) begin
    rise_open = rise_tot;
    fall_open = fall_tot;
  end
  assign nbits = 6'(rise_tot - rise_open);
  assign nfall = 6'(fall_tot - fall_open);
  always @(posedge sync_n) begin
    word   = shreg;
    frames = frames + 1;
  end
endmodule

/* sim/tb_dac_serial_host_write.sv */
`timescale 1ns/1ns
module tb_dac_serial_host_write;
  import dac_host_pkg::*;
  logic        mclk;
  logic        sys_rst;
  logic        req_valid;
  logic        lsb_first_port;
  logic [3:0]  req_cmd;
  logic [3:0]  req_addr;
  logic [3:0]  req_top;
  logic [19:0] req_payload;
  logic        req_ready_q;
  logic        frame_done_q;
  logic        sync_n_q;
  logic        sclk_q;
  logic        sdin_q;
  logic [31:0] dev_word;
  logic [5:0]  dev_bits;
  logic [5:0]  dev_falls;
  int          dev_frames;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  dac_serial_host_write u_dut (.mclk(mclk), .sys_rst(sys_rst), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_addr(req_addr), .req_payload(req_payload), .req_top(req_top),
    .lsb_first_port(lsb_first_port), .req_ready_q(req_ready_q), .frame_done_q(frame_done_q),
    .sync_n_q(sync_n_q), .sclk_q(sclk_q), .sdin_q(sdin_q));
  dac_device_model u_dev (.sync_n(sync_n_q), .sclk(sclk_q), .sdin(sdin_q), .word(dev_word),
    .nbits(dev_bits), .nfall(dev_falls), .frames(dev_frames));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Held until accepted; a busy block simply leaves it waiting
  task automatic post(input frame_t w, input logic lsb);
    int n;
    n = 0;
    @(posedge mclk);
    req_valid <= 1'b1;
    {req_top, req_cmd, req_addr, req_payload} <= w;
    lsb_first_port <= lsb;
    do begin
      @(posedge mclk);
      n++;
    end while (req_ready_q !== 1'b1 && n < 3000);
    req_valid <= 1'b0;
  endtask
  task automatic wait_done;
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (frame_done_q !== 1'b1 && n < 3000);
  endtask
  task automatic frame_test(input frame_t w, input logic lsb);
    int f0;
    f0 = dev_frames;
    post(w, lsb);
    wait_done();
    check("word", dev_word, w);
    check("bits", {26'h0, dev_bits}, 32'h20);
    check("falls", {26'h0, dev_falls}, 32'h20);
    check("frames", 32'(dev_frames - f0), 32'h1);
  endtask
  // Every command code, both port bit orders
  task automatic t_fields;
    for (int i = 0; i < 16; i++) begin
      frame_test({4'h9, 4'(i), ~4'(i), 20'h96C3A ^ 20'(i * 4369)}, 1'(i));
    end
    $display("fields test done");
  endtask
  task automatic t_back_to_back;
    int f0;
    f0 = dev_frames;
    post(32'hF1A5_5A0F, 1'b0);
    post(32'h0E5A_A5F0, 1'b1);
    wait_done();
    check("b2b frames", 32'(dev_frames - f0), 32'h2);
    check("b2b word", dev_word, 32'h0E5A_A5F0);
    $display("back to back test done");
  endtask
  task automatic t_reset_mid;
    post(32'h1234_5678, 1'b0);
    repeat (60) @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    check("sync after reset", {31'h0, sync_n_q}, 32'h1);
    check("sclk after reset", {31'h0, sclk_q}, 32'h0);
    frame_test(32'h8765_4321, 1'b1);
    $display("reset test done");
  endtask
  initial begin
    sys_rst = 1'b1;
    req_valid = 1'b0;
    lsb_first_port = 1'b0;
    {req_top, req_cmd, req_addr, req_payload} = 32'h0;
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    t_fields();
    t_back_to_back();
    t_reset_mid();
    end_sim();
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end
endmodule
bind dac_serial_host_write dac_host_props u_props (.mclk(mclk), .sys_rst(sys_rst),
  .req_valid(req_valid), .req_ready_q(req_ready_q), .frame_done_q(frame_done_q),
  .sync_n_q(sync_n_q), .sclk_q(sclk_q), .sdin_q(sdin_q));
